/* design/scsb_pkg.sv */
// Package with constants and carrier types for the SPI chip status byte block.
package scsb_pkg;

    // Status byte layout.
    localparam int STAT_W        = 8;
    localparam int RDY_BIT       = 7;
    localparam int STATE_MSB     = 6;
    localparam int STATE_LSB     = 4;
    localparam int COUNT_MSB     = 3;
    localparam int COUNT_LSB     = 0;
    localparam int COUNT_W       = 4;
    localparam int FIFO_CNT_W    = 7;
    localparam int BIT_CNT_W     = 3;

    // Saturation value of the four-bit buffer count.
    localparam logic [FIFO_CNT_W-1:0] COUNT_SAT = 7'h0F;
    // Direction bit position inside the header byte.
    localparam int DIR_BIT       = 7;
    // Reset values.
    localparam logic [STAT_W-1:0]    STATUS_RST = 8'h80;
    localparam logic [BIT_CNT_W-1:0] BIT_CNT_RST = 3'h7;

    // Main state codes reported in bits six to four.
    localparam logic [2:0] ST_IDLE      = 3'h0;
    localparam logic [2:0] ST_RX        = 3'h1;
    localparam logic [2:0] ST_TX        = 3'h2;
    localparam logic [2:0] ST_FAST_TX   = 3'h3;
    localparam logic [2:0] ST_CALIB     = 3'h4;
    localparam logic [2:0] ST_SETTLE    = 3'h5;
    localparam logic [2:0] ST_RX_OVERRUN = 3'h6;
    localparam logic [2:0] ST_TX_STARVED = 3'h7;

    // Radio condition as reported by the main state machine.
    typedef enum logic [3:0] {
        SCSB_RADIO_IDLE,
        SCSB_RADIO_RX,
        SCSB_RADIO_TX,
        SCSB_RADIO_FAST_TX,
        SCSB_RADIO_CALIB,
        SCSB_RADIO_SETTLE,
        SCSB_RADIO_RX_OVERRUN,
        SCSB_RADIO_TX_STARVED,
        SCSB_RADIO_TRANSIT
    } scsb_radio_t;

    // Inputs from the rest of the chip that feed the status byte.
    typedef struct packed {
        logic                  crystal_stable;
        logic                  sleep_or_osc_off;
        scsb_radio_t           radio;
        logic [FIFO_CNT_W-1:0] rx_fill;
        logic [FIFO_CNT_W-1:0] tx_free;
    } scsb_chip_t;

    // Serial pins after synchronisation.
    typedef struct packed {
        logic sclk;
        logic sdi;
        logic cs_n;
    } scsb_pins_t;

endpackage : scsb_pkg

/* design/scsb_status.sv */
// SPI slave front end that shifts the chip status byte out on the serial output.
// Operation
// R1 - Status byte shifts out for every header, data or strobe byte.
// R2 - Top bit is not-ready flag; host clocks only after it goes low.
// R3 - Flag stays high until supply and crystal are stable, then low.
// R4 - Bits six to four carry the three-bit main state code.
// R5 - Code 000 means idle, also used for some transitional states.
// R6 - Codes 001 receive, 010 transmit, 011 fast transmit standby.
// R7 - Code 100 synthesiser calibration, 101 loop settling.
// R8 - Code 110 after receive overrun; host flushes receive buffer.
// R9 - Code 111 after transmit underflow; host flushes transmit buffer.
// R10 - Direction bit one: low nibble is bytes waiting in receive buffer.
// R11 - Direction bit zero: low nibble is free transmit buffer places.
// R12 - Buffer count saturates at fifteen.
// R13 - Idle keeps crystal and digital core powered, rest powered down.
// R14 - Host changes frequency settings only while idle is reported.
// R15 - All bytes shift most significant bit first.
// R16 - Host waits for serial output low before sending header.
// R17 - Output goes low at select unless sleeping or oscillator off.
`timescale 1ns/1ps
module scsb_status (
    input  wire logic                clk,
    input  wire logic                resetn,
    input  wire logic                sclk,
    input  wire logic                sdi,
    input  wire logic                chip_select_low_n,
    input  wire scsb_pkg::scsb_chip_t chip,
    output logic                     sdo,
    output logic                     sdo_oe_n,
    output logic                     osc_not_ready_flag,
    output logic [2:0]               state_code,
    output logic                     core_powered,
    output logic                     analog_powered,
    output logic                     byte_done
);
    // Whole module state in one packed struct.
    typedef struct packed {
        logic                           sclk_prev;
        logic                           in_frame;
        logic                           first_byte;
        logic                           read_dir;
        logic [scsb_pkg::BIT_CNT_W-1:0] bit_cnt;
        logic [scsb_pkg::STAT_W-1:0]    tx_shift;
        logic                           sdo;
        logic                           sdo_oe_n;
        logic                           byte_done;
    } scsb_state_t;

    scsb_state_t          st_ff;
    scsb_state_t          nxt_st;
    scsb_pkg::scsb_pins_t pins;
    logic [2:0]           code;
    logic                 not_ready;
    logic                 rise;
    logic                 fall;
    logic [scsb_pkg::STAT_W-1:0] status_now;
    logic                 first_rise;
    logic                 dir_sel;

    // Pins cross into the clock domain through two flops.
    scsb_sync #(
        .WIDTH (3)
    ) u_sync (
        .clk      (clk),
        .resetn   (resetn),
        .async_in ({sclk, sdi, chip_select_low_n}),
        .sync_out (pins)
    );

    // Saturating four-bit count from a wider buffer level.
    function automatic logic [scsb_pkg::COUNT_W-1:0] sat_count(
        input logic [scsb_pkg::FIFO_CNT_W-1:0] level
    );
        // R12 saturate at fifteen
        if (level >= scsb_pkg::COUNT_SAT)
            sat_count = scsb_pkg::COUNT_SAT[scsb_pkg::COUNT_W-1:0];
        else
            sat_count = level[scsb_pkg::COUNT_W-1:0];
    endfunction : sat_count

    // Map the radio condition onto the reported state code.
    always_comb
    begin
        // R4 state code field
        case (chip.radio)
            // R5 idle and transitions
            scsb_pkg::SCSB_RADIO_IDLE:       code = scsb_pkg::ST_IDLE;
            scsb_pkg::SCSB_RADIO_TRANSIT:    code = scsb_pkg::ST_IDLE;
            // R6 active mode codes
            scsb_pkg::SCSB_RADIO_RX:         code = scsb_pkg::ST_RX;
            scsb_pkg::SCSB_RADIO_TX:         code = scsb_pkg::ST_TX;
            scsb_pkg::SCSB_RADIO_FAST_TX:    code = scsb_pkg::ST_FAST_TX;
            // R7 synthesiser codes
            scsb_pkg::SCSB_RADIO_CALIB:      code = scsb_pkg::ST_CALIB;
            scsb_pkg::SCSB_RADIO_SETTLE:     code = scsb_pkg::ST_SETTLE;
            // R8 receive overrun code
            scsb_pkg::SCSB_RADIO_RX_OVERRUN: code = scsb_pkg::ST_RX_OVERRUN;
            // R9 transmit underflow code
            scsb_pkg::SCSB_RADIO_TX_STARVED: code = scsb_pkg::ST_TX_STARVED;
            default:                         code = scsb_pkg::ST_IDLE;
        endcase
    end

    // R3 flag follows crystal
    assign not_ready = ~chip.crystal_stable;
    assign rise      = pins.sclk & ~st_ff.sclk_prev;
    assign fall      = ~pins.sclk & st_ff.sclk_prev;

    // The direction bit arrives with the first rise of a frame, and the
    // count nibble must already follow it when the shifter is loaded.
    assign first_rise = rise & st_ff.first_byte & (st_ff.bit_cnt == scsb_pkg::BIT_CNT_RST);
    assign dir_sel    = first_rise ? pins.sdi : st_ff.read_dir;

    // Elaboration check: the shifter is built for a status byte with the flag on top.
    if (scsb_pkg::RDY_BIT != scsb_pkg::STAT_W - 1 || scsb_pkg::COUNT_W > scsb_pkg::FIFO_CNT_W)
    begin : g_bad_layout
        $error("Status byte layout does not fit the shifter.");
    end

    // Assemble the byte; direction picks which buffer count is shown.
    always_comb
    begin
        status_now = '0;
        // R2 flag in top bit
        status_now[scsb_pkg::RDY_BIT] = not_ready;
        status_now[scsb_pkg::STATE_MSB:scsb_pkg::STATE_LSB] = code;
        // R10 read shows fill
        if (dir_sel)
            status_now[scsb_pkg::COUNT_MSB:scsb_pkg::COUNT_LSB] = sat_count(chip.rx_fill);
        // R11 write shows free
        else
            status_now[scsb_pkg::COUNT_MSB:scsb_pkg::COUNT_LSB] = sat_count(chip.tx_free);
    end

    // Frame tracking, bit sampling on rising edges, shifting on falling edges.
    always_comb
    begin
        nxt_st           = st_ff;
        nxt_st.sclk_prev = pins.sclk;
        nxt_st.byte_done = 1'b0;
        if (pins.cs_n)
        begin
            nxt_st.in_frame   = 1'b0;
            nxt_st.first_byte = 1'b1;
            nxt_st.bit_cnt    = scsb_pkg::BIT_CNT_RST;
            nxt_st.sdo_oe_n   = 1'b1;
            nxt_st.sdo        = 1'b1;
        end
        else if (!st_ff.in_frame)
        begin
            nxt_st.in_frame = 1'b1;
            nxt_st.sdo_oe_n = 1'b0;
            // R17 output low at select
            nxt_st.sdo      = not_ready | chip.sleep_or_osc_off;
        end
        else
        begin
            // Before the first clock the pin tracks readiness.
            if (st_ff.first_byte && st_ff.bit_cnt == scsb_pkg::BIT_CNT_RST && !rise)
            begin
                nxt_st.sdo = not_ready | chip.sleep_or_osc_off;
            end
            if (rise)
            begin
                if (first_rise)
                begin
                    // R10 latch direction bit
                    nxt_st.read_dir = pins.sdi;
                    // R1 first status bit
                    nxt_st.sdo      = status_now[scsb_pkg::RDY_BIT];
                    nxt_st.tx_shift = {status_now[scsb_pkg::STAT_W-2:0], 1'b0};
                end
                nxt_st.bit_cnt = st_ff.bit_cnt - 3'h1;
                if (st_ff.bit_cnt == '0)
                begin
                    nxt_st.byte_done  = 1'b1;
                    nxt_st.first_byte = 1'b0;
                end
            end
            if (fall)
            begin
                if (st_ff.bit_cnt == scsb_pkg::BIT_CNT_RST)
                begin
                    // R1 reload for next byte
                    nxt_st.tx_shift = {status_now[scsb_pkg::STAT_W-2:0], 1'b0};
                    nxt_st.sdo      = status_now[scsb_pkg::RDY_BIT];
                end
                else
                begin
                    // R15 shift next bit
                    nxt_st.sdo      = st_ff.tx_shift[scsb_pkg::STAT_W-1];
                    nxt_st.tx_shift = {st_ff.tx_shift[scsb_pkg::STAT_W-2:0], 1'b0};
                end
            end
        end
    end

    // Registers the module state.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_ff            <= '0;
            st_ff.sclk_prev  <= 1'b1;
            st_ff.first_byte <= 1'b1;
            st_ff.bit_cnt    <= scsb_pkg::BIT_CNT_RST;
            st_ff.tx_shift   <= scsb_pkg::STATUS_RST;
            st_ff.sdo        <= 1'b1;
            st_ff.sdo_oe_n   <= 1'b1;
        end
        else
            st_ff <= nxt_st;
    end

    assign sdo                = st_ff.sdo;
    assign sdo_oe_n           = st_ff.sdo_oe_n;
    assign byte_done          = st_ff.byte_done;
    assign osc_not_ready_flag = not_ready;
    assign state_code         = code;
    // R13 idle power plan
    assign core_powered       = 1'b1;
    assign analog_powered     = (code != scsb_pkg::ST_IDLE) | (chip.radio == scsb_pkg::SCSB_RADIO_TRANSIT);

endmodule : scsb_status

/* design/scsb_sync.sv */
// Two-flop synchroniser for the serial pins.
`timescale 1ns/1ps
module scsb_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    // Single packed state: both stages.
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } scsb_sync_state_t;

    scsb_sync_state_t state_ff;
    scsb_sync_state_t nxt_state;

    // Elaboration check: a zero-width synchroniser cannot be built.
    if (WIDTH < 1)
    begin : g_bad_width
        $error("WIDTH must be at least one.");
    end

    // The first stage is read only by the second stage.
    always_comb
    begin
        nxt_state        = state_ff;
        nxt_state.meta   = async_in;
        nxt_state.stable = state_ff.meta;
    end

    // Select idles high so reset loads ones.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            state_ff <= '1;
        else
            state_ff <= nxt_state;
    end

    assign sync_out = state_ff.stable;

endmodule : scsb_sync

/* tb/scsb_host_model.sv */
// Host model: SPI master in mode 0, serial clock of 16 system cycles.
`timescale 1ns/1ps
module scsb_host_model (
    input  wire logic clk,
    input  wire logic sdo,
    input  wire logic sdo_oe_n,
    output logic      sclk,
    output logic      sdi,
    output logic      cs_n
);
    // Idle levels: clock stands low, select high.
    initial
    begin
        sclk = 1'b0;
        sdi  = 1'b0;
        cs_n = 1'b1;
    end
    // Waits n falling edges, where every host change is launched.
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    // Lowers select and, if asked, waits a bounded time for the ready level.
    task automatic select(input logic wait_rdy, output logic ok);
        int i;
        tick(1);
        cs_n = 1'b0;
        i    = 0;
        // ready wait: no clock until the output is driven low.
        while (wait_rdy && (sdo_oe_n !== 1'b0 || sdo !== 1'b0) && i < 40)
        begin
            tick(1);
            i++;
        end
        ok = (i < 40);
    endtask : select
    // msb first: data set at the fall, status sampled at each rise.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int b = 7; b >= 0; b--)
        begin
            sdi = tx[b];
            tick(8);
            rx[b] = sdo;
            sclk  = 1'b1;
            tick(8);
            sclk  = 1'b0;
        end
    endtask : xfer
    // Raises select; the parked data line shows the inverse of its last bit.
    task automatic deselect();
        cs_n = 1'b1;
        sdi  = ~sdi;
        tick(10);
    endtask : deselect
endmodule : scsb_host_model

/* tb/scsb_status_monitor.sv */
// Checker on the ports of the status byte front end.
`timescale 1ns/1ps
module scsb_status_monitor (
    input wire logic                 clk,
    input wire logic                 resetn,
    input wire logic                 sclk,
    input wire logic                 sdi,
    input wire logic                 chip_select_low_n,
    input wire scsb_pkg::scsb_chip_t chip,
    input wire logic                 sdo,
    input wire logic                 sdo_oe_n,
    input wire logic                 osc_not_ready_flag,
    input wire logic [2:0]           state_code,
    input wire logic                 core_powered,
    input wire logic                 analog_powered,
    input wire logic                 byte_done
);
    // All checks run on the system clock and rest during reset.
    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    a_flag_follows_xtal: assert property (osc_not_ready_flag == !chip.crystal_stable)
        else $error("not ready flag wrong");
    a_analog_off_idle:
        assert property (analog_powered == (chip.radio != scsb_pkg::SCSB_RADIO_IDLE))
        else $error("analog power wrong");
    a_code_plain:
        assert property (chip.radio != scsb_pkg::SCSB_RADIO_TRANSIT
            |-> state_code == chip.radio[2:0]) else $error("state code wrong");
    a_transit_idle:
        assert property (chip.radio == scsb_pkg::SCSB_RADIO_TRANSIT |-> state_code == 3'h0)
        else $error("transit code wrong");
    a_ready_low_select:
        assert property ($fell(chip_select_low_n) && chip.crystal_stable
            && !chip.sleep_or_osc_off |-> ##[2:4] (!sdo_oe_n && !sdo))
        else $error("output not low at select");
    a_not_ready_high:
        assert property ($fell(chip_select_low_n) && !chip.crystal_stable
            |-> ##[2:4] (!sdo_oe_n && sdo)) else $error("not ready not shown");
    a_oe_off_idle: assert property (chip_select_low_n [*5] |-> sdo_oe_n)
        else $error("output driven while deselected");
    a_done_one_cycle: assert property (byte_done |=> (!byte_done) [*8])
        else $error("byte done too long");
endmodule : scsb_status_monitor

/* tb/spi_chip_status_byte_test.sv */
// Self-checking bench for the status byte front end.
`timescale 1ns/1ps
module spi_chip_status_byte_test;
    logic                 clk, resetn, sclk, sdi, cs_n, sdo, sdo_oe_n;
    logic                 flag, core_on, analog_on, done;
    logic [2:0]           code;
    scsb_pkg::scsb_chip_t chip;
    logic [6:0]           lv [5] = '{7'h00, 7'h0E, 7'h0F, 7'h10, 7'h40};
    int                   bad_count = 0;
    int                   comparisons = 0;
    int                   cycles = 0;
    int                   done_seen = 0;
    // Free-running 100 MHz system clock.
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    scsb_status i_dut (.clk(clk), .resetn(resetn), .sclk(sclk), .sdi(sdi),
        .chip_select_low_n(cs_n), .chip(chip), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
        .osc_not_ready_flag(flag), .state_code(code), .core_powered(core_on),
        .analog_powered(analog_on), .byte_done(done));
    scsb_host_model i_host (.clk(clk), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .sclk(sclk),
        .sdi(sdi), .cs_n(cs_n));
    // Counts byte-done pulses half a cycle after they are launched.
    always @(negedge clk)
    begin
        if (done === 1'b1)
            done_seen++;
    end
    // Compares one value and counts the result.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Expected status byte for the given direction.
    function automatic logic [7:0] exp_stat(input logic dir);
        logic [6:0] n;
        n = dir ? chip.rx_fill : chip.tx_free;
        if (n > 7'h0F)
            n = 7'h0F;
        return {~chip.crystal_stable,
            (chip.radio == scsb_pkg::SCSB_RADIO_TRANSIT) ? 3'h0 : chip.radio[2:0], n[3:0]};
    endfunction : exp_stat
    // One frame of one or two bytes, each returning the status byte.
    task automatic frame(input logic [7:0] hdr, input logic [7:0] dat, input logic two);
        logic [7:0] rx;
        logic       ok;
        int         d0;
        d0 = done_seen;
        i_host.select(1'b1, ok);
        check({7'h00, ok}, 8'h01);
        i_host.xfer(hdr, rx);
        check(rx, exp_stat(hdr[7]));
        if (two)
        begin
            i_host.xfer(dat, rx);
            check(rx, exp_stat(hdr[7]));
        end
        i_host.deselect();
        check(8'(done_seen - d0), two ? 8'h02 : 8'h01);
    endtask : frame
    // Select while the crystal is unsettled: the output must show not ready.
    task automatic t_not_ready();
        logic ok;
        chip.crystal_stable = 1'b0;
        i_host.select(1'b0, ok);
        i_host.tick(6);
        check({6'h00, sdo, flag}, 8'h03);
        i_host.deselect();
        chip.crystal_stable = 1'b1;
        $display("test not_ready done");
    endtask : t_not_ready
    // Every radio condition, with the code port and the power flags.
    task automatic t_codes();
        logic [7:0] e;
        for (int r = 0; r < 9; r++)
        begin
            chip.radio   = scsb_pkg::scsb_radio_t'(r);
            chip.tx_free = 7'h05;
            frame(8'h3F, 8'h00, 1'b0);
            e = exp_stat(1'b0);
            check({5'h00, code}, {5'h00, e[6:4]});
            check({6'h00, core_on, analog_on}, {6'h00, 1'b1, r != 0});
        end
        // return to idle and read the idle code back.
        chip.radio = scsb_pkg::SCSB_RADIO_IDLE;
        frame(8'h3F, 8'h00, 1'b0);
        check({5'h00, code}, {5'h00, scsb_pkg::ST_IDLE});
        $display("test codes done");
    endtask : t_codes
    // Boundary fill levels in both directions; data bit seven never flips direction.
    task automatic t_counts();
        chip.radio = scsb_pkg::SCSB_RADIO_RX;
        for (int k = 0; k < 5; k++)
        begin
            chip.rx_fill = lv[k];
            chip.tx_free = lv[4-k];
            frame(8'hFF, 8'h00, 1'b1);
            frame(8'h3F, 8'h80, 1'b1);
        end
        $display("test counts done");
    endtask : t_counts
    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    // Cuts a hang short well after the tests should have finished.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            $display("ERROR %0t: timeout", $time);
            test_done();
        end
    end
    // Reset for 20 cycles, then the scenarios in turn.
    initial
    begin
        resetn = 1'b0;
        chip   = '{1'b1, 1'b0, scsb_pkg::SCSB_RADIO_IDLE, 7'h00, 7'h00};
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        t_not_ready();
        t_codes();
        t_counts();
        test_done();
    end
endmodule : spi_chip_status_byte_test
bind scsb_status scsb_status_monitor i_mon (.clk(clk), .resetn(resetn), .sclk(sclk),
    .sdi(sdi), .chip_select_low_n(chip_select_low_n), .chip(chip), .sdo(sdo),
    .sdo_oe_n(sdo_oe_n), .osc_not_ready_flag(osc_not_ready_flag), .state_code(state_code),
    .core_powered(core_powered), .analog_powered(analog_powered), .byte_done(byte_done));
